/* File: include/seep_regs.vh */
// Constants for the two-wire serial memory slave (no registers reach software)
`ifndef SEEP_REGS_VH
`define SEEP_REGS_VH

// Array geometry: two address bytes, upper high bits unused
`define SEEP_ADDR_W     12
`define SEEP_DATA_W     8
`define SEEP_MEM_DEPTH  4096
`define SEEP_AHI_MSB    3
`define SEEP_ADDR_ONE   12'h001
`define SEEP_ADDR_RST   12'h000

// Control byte layout
`define SEEP_CTRL_CODE  4'ha
`define SEEP_CODE_MSB   7
`define SEEP_CODE_LSB   4
`define SEEP_CS_MSB     3
`define SEEP_CS_LSB     1
`define SEEP_RW_BIT     0
`define SEEP_MSB        7

// Bit counting and byte phases
`define SEEP_CNT_W      4
`define SEEP_CNT_RST    4'h0
`define SEEP_CNT_ONE    4'h1
`define SEEP_BYTE_BITS  4'h8
`define SEEP_PH_CTRL    2'h0
`define SEEP_PH_AHI     2'h1
`define SEEP_PH_ALO     2'h2
`define SEEP_PH_DATA    2'h3
`define SEEP_PH_ONE     2'h1

// Input synchroniser: scl, sda, three chip select pins
`define SEEP_SYNC_W     5
`define SEEP_SYNC_RST   5'h03
`define SEEP_SYNC_SCL   0
`define SEEP_SYNC_SDA   1
`define SEEP_SYNC_CSL   2
`define SEEP_SYNC_CSH   4

// Internal write cycle timing
`define SEEP_TWC_NS     5000000
`define SEEP_CLK_NS     50
`define SEEP_BUSY_W     17
`define SEEP_BUSY_ZERO  17'h0_0000
`define SEEP_BUSY_ONE   17'h0_0001

`endif

/* File: rtl/seep_mem.v */
// Byte array with one write port and a registered read port
`timescale 1ns/1ps
`include "seep_regs.vh"

module seep_mem (
  // Clock
  input  wire                      i_clk,
  // Write port
  input  wire                      i_we,
  input  wire [`SEEP_ADDR_W-1:0]   i_waddr,
  input  wire [`SEEP_DATA_W-1:0]   i_wdata,
  // Read port
  input  wire [`SEEP_ADDR_W-1:0]   i_raddr,
  output reg  [`SEEP_DATA_W-1:0]   o_rdata
);

  reg [`SEEP_DATA_W-1:0] mem_q [0:`SEEP_MEM_DEPTH-1];

  // Read data from a flop so the shifter sees a stable byte
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule

/* File: rtl/seep_top.v */
// Two-wire serial memory slave: polling, current, random and sequential reads
`timescale 1ns/1ps
`include "seep_regs.vh"

module seep_top #(
  parameter integer WRITE_CYCLES = `SEEP_TWC_NS / `SEEP_CLK_NS
) (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rstn,
  // Serial bus pins
  input  wire i_scl,
  input  wire i_sda,
  output reg  o_sda_out,
  output reg  o_sda_oe,
  // Chip select straps
  input  wire i_chip_select_bit_high,
  input  wire i_chip_select_bit_mid,
  input  wire i_chip_select_bit_low,
  // Status
  output reg  o_write_busy
);

  // One-hot protocol states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  localparam [`SEEP_BUSY_W-1:0] BUSY_LOAD = WRITE_CYCLES[`SEEP_BUSY_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  ////////////////////////////////////////////////////////////////////////////

  wire [`SEEP_SYNC_W-1:0] raw_in;
  reg  [`SEEP_SYNC_W-1:0] sync1_q;
  reg  [`SEEP_SYNC_W-1:0] sync2_q;
  reg  [`SEEP_SYNC_W-1:0] sync3_q;
  reg  [`SEEP_SYNC_W-1:0] stab_q;
  reg                     scl_prev_q;
  reg                     sda_prev_q;
  wire [`SEEP_SYNC_W-1:0] sync_rst = `SEEP_SYNC_RST; // Idle bus levels, straps low

  assign raw_in = {i_chip_select_bit_high, i_chip_select_bit_mid,
                   i_chip_select_bit_low, i_sda, i_scl};

  // Four flops per pin; value accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `SEEP_SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          sync1_q[gi] <= sync_rst[gi];
          sync2_q[gi] <= sync_rst[gi];
          sync3_q[gi] <= sync_rst[gi];
          stab_q[gi]  <= sync_rst[gi];
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            stab_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire                 scl_s = stab_q[`SEEP_SYNC_SCL];
  wire                 sda_s = stab_q[`SEEP_SYNC_SDA];
  wire [2:0]           cs_s  = stab_q[`SEEP_SYNC_CSH:`SEEP_SYNC_CSL];

  // Previous filtered levels for edge and condition detection
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise   = scl_s & ~scl_prev_q;
  wire scl_fall   = ~scl_s & scl_prev_q;
  // Data moving while clock is high marks Start or Stop
  wire start_det  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Control byte decode
  ////////////////////////////////////////////////////////////////////////////

  function ctrl_match;
    input [`SEEP_DATA_W-1:0] b;
    input [2:0]              cs;
    begin
      ctrl_match = (b[`SEEP_CODE_MSB:`SEEP_CODE_LSB] == `SEEP_CTRL_CODE) &&
                   (b[`SEEP_CS_MSB:`SEEP_CS_LSB] == cs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  ////////////////////////////////////////////////////////////////////////////

  reg [5:0]               state_q;
  reg [`SEEP_CNT_W-1:0]   cnt_q;
  reg [1:0]               phase_q;
  reg [`SEEP_DATA_W-1:0]  shift_q;
  reg                     rw_q;
  reg                     macked_q;
  reg [`SEEP_ADDR_W-1:0]  addr_q;
  reg [`SEEP_ADDR_W-1:0]  wr_addr_q;
  reg [`SEEP_DATA_W-1:0]  wr_data_q;
  reg                     wr_pend_q;
  reg                     mem_we_q;
  reg [`SEEP_BUSY_W-1:0]  busy_cnt_q;
  wire [`SEEP_DATA_W-1:0] rd_data;

  // Start and Stop win over any bit activity in the same cycle
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q   <= ST_IDLE;
      cnt_q     <= `SEEP_CNT_RST;
      phase_q   <= `SEEP_PH_CTRL;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      macked_q  <= 1'b0;
      addr_q    <= `SEEP_ADDR_RST;
      wr_addr_q <= `SEEP_ADDR_RST;
      wr_data_q <= 8'h00;
      wr_pend_q <= 1'b0;
      mem_we_q  <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      mem_we_q  <= 1'b0;
      o_sda_out <= 1'b0;
      if (stop_det) begin
        state_q   <= ST_IDLE;
        o_sda_oe  <= 1'b0;
        wr_pend_q <= 1'b0;
        if (wr_pend_q) begin
          mem_we_q <= 1'b1;
          addr_q   <= wr_addr_q + `SEEP_ADDR_ONE;
        end
      end else if (start_det) begin
        // A restart drops any pending data but keeps the address
        state_q   <= ST_RX;
        cnt_q     <= `SEEP_CNT_RST;
        phase_q   <= `SEEP_PH_CTRL;
        o_sda_oe  <= 1'b0;
        wr_pend_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[`SEEP_MSB-1:0], sda_s};
              cnt_q   <= cnt_q + `SEEP_CNT_ONE;
            end else if (scl_fall && cnt_q == `SEEP_BYTE_BITS) begin
              cnt_q <= `SEEP_CNT_RST;
              case (phase_q)
                `SEEP_PH_CTRL: begin
                  // Busy array refuses reads and writes alike
                  if (ctrl_match(shift_q, cs_s) && !o_write_busy) begin
                    rw_q     <= shift_q[`SEEP_RW_BIT];
                    o_sda_oe <= 1'b1;
                    state_q  <= ST_ACK;
                  end else begin
                    state_q <= ST_WAIT;
                  end
                end
                `SEEP_PH_AHI: begin
                  addr_q[`SEEP_ADDR_W-1:`SEEP_DATA_W] <= shift_q[`SEEP_AHI_MSB:0];
                  o_sda_oe <= 1'b1;
                  state_q  <= ST_ACK;
                end
                `SEEP_PH_ALO: begin
                  addr_q[`SEEP_DATA_W-1:0] <= shift_q;
                  o_sda_oe <= 1'b1;
                  state_q  <= ST_ACK;
                end
                default: begin
                  // Only the latest data byte is kept for the commit
                  wr_data_q <= shift_q;
                  wr_addr_q <= addr_q;
                  wr_pend_q <= 1'b1;
                  o_sda_oe  <= 1'b1;
                  state_q   <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                state_q  <= ST_TX;
                o_sda_oe <= ~rd_data[`SEEP_MSB];
                shift_q  <= {rd_data[`SEEP_MSB-1:0], 1'b0};
                cnt_q    <= `SEEP_CNT_ONE;
              end else begin
                o_sda_oe <= 1'b0;
                state_q  <= ST_RX;
                if (phase_q != `SEEP_PH_DATA) begin
                  phase_q <= phase_q + `SEEP_PH_ONE;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == `SEEP_BYTE_BITS) begin
                // Counter wraps naturally past the top address
                o_sda_oe <= 1'b0;
                state_q  <= ST_MACK;
                addr_q   <= addr_q + `SEEP_ADDR_ONE;
                cnt_q    <= `SEEP_CNT_RST;
              end else begin
                o_sda_oe <= ~shift_q[`SEEP_MSB];
                shift_q  <= {shift_q[`SEEP_MSB-1:0], 1'b0};
                cnt_q    <= cnt_q + `SEEP_CNT_ONE;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              macked_q <= ~sda_s;
            end else if (scl_fall) begin
              if (macked_q) begin
                state_q  <= ST_TX;
                o_sda_oe <= ~rd_data[`SEEP_MSB];
                shift_q  <= {rd_data[`SEEP_MSB-1:0], 1'b0};
                cnt_q    <= `SEEP_CNT_ONE;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_WAIT: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            state_q  <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal write cycle timer
  ////////////////////////////////////////////////////////////////////////////

  // Busy from the commit until the count runs out; polling sees no ack
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      busy_cnt_q   <= `SEEP_BUSY_ZERO;
      o_write_busy <= 1'b0;
    end else if (mem_we_q) begin
      busy_cnt_q   <= BUSY_LOAD;
      o_write_busy <= 1'b1;
    end else if (busy_cnt_q != `SEEP_BUSY_ZERO) begin
      busy_cnt_q   <= busy_cnt_q - `SEEP_BUSY_ONE;
      o_write_busy <= (busy_cnt_q != `SEEP_BUSY_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array
  ////////////////////////////////////////////////////////////////////////////

  seep_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we_q),
    .i_waddr (wr_addr_q),
    .i_wdata (wr_data_q),
    .i_raddr (addr_q),
    .o_rdata (rd_data)
  );

endmodule

/* File: verif/seep_chk.sv */
// Pin-level assertions for the serial memory slave
`timescale 1ns/1ps
module seep_chk #(parameter integer WRITE_CYCLES = 20) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Bus pins and status
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_write_busy
);
  reg  [16:0] busy_q;
  reg  [7:0]  stop_q;
  reg  [7:0]  hi_q;
  reg         sda_q;
  wire        stop_ev = i_scl && i_sda && !sda_q;
  wire        start_ev = i_scl && !i_sda && sda_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////
  // Busy length, age of last pin Stop, length of SCL high
  always @(posedge i_clk) begin
    sda_q <= i_sda;
    busy_q <= (i_rstn && o_write_busy) ? busy_q + 17'h0_0001 : 17'h0_0000;
    stop_q <= !i_rstn ? 8'hff : stop_ev ? 8'h00 : stop_q + {7'h00, stop_q != 8'hff};
    hi_q <= (i_rstn && i_scl) ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
  end
  ////////////////////////////////////////////////////////////
  property p_out_low; !o_sda_out; endproperty
  a_out_low: assert property (p_out_low) else $error("sda driven high");
  property p_busy_len; $fell(o_write_busy) |-> busy_q == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_busy_quiet; o_write_busy |-> !o_sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer during write cycle");
  property p_busy_stop; $rose(o_write_busy) |-> stop_q <= 8'h0c; endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("write cycle without Stop");
  property p_stop_rel; stop_ev |-> ##8 !o_sda_oe; endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("drive after Stop");
  property p_start_rel; start_ev |-> ##8 !o_sda_oe; endproperty
  a_start_rel: assert property (p_start_rel) else $error("drive after Start");
  property p_oe_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data moved with clock high");
  property p_oe_hold; $rose(o_sda_oe) |-> o_sda_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
  property p_idle; hi_q > 8'h14 |-> !o_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("drive on idle bus");
endmodule

bind seep_top seep_chk #(.WRITE_CYCLES(WRITE_CYCLES)) seep_chk_inst (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_write_busy(o_write_busy));

/* File: verif/seep_bfm.sv */
// Bus master model: drives the clock and pulls data low
`timescale 1ns/1ps
module seep_bfm (
  // Clock
  input  wire i_clk,
  // Bus
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda_low
);
  integer i;
  reg     r;
  // Idle bus: clock stands high, data left to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic wt(input integer n);
    repeat (n) @(negedge i_clk);
  endtask
  // 400 ns bit: low six clocks, high two; slave answers about five clocks after a fall
  task automatic bit_io(input b, output s);
    begin
      o_scl = 1'b0;
      wt(2);
      o_sda_low = !b;
      wt(4);
      o_scl = 1'b1;
      wt(1);
      s = i_sda;
      wt(1);
    end
  endtask
  // Data edge with clock high: Start is (0,1), Stop is (1,0)
  task automatic frame(input a, input b);
    begin
      o_scl = 1'b0;
      wt(2);
      o_sda_low = a;
      wt(6);
      o_scl = 1'b1;
      wt(6);
      o_sda_low = b;
      wt(6);
    end
  endtask
  // MSB first; ninth clock reads the acknowledge
  task automatic put_byte(input [7:0] b, output ack);
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
    end
  endtask
  // Read a byte, then acknowledge it or not
  task automatic get_byte(input m_ack, output [7:0] d);
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, r);
        d[i] = r;
      end
      bit_io(!m_ack, r);
    end
  endtask
endmodule

/* File: verif/test_serial_eeprom_read_ack_poll.sv */
// Bench for the serial memory slave: polling, random, current and sequential reads
`timescale 1ns/1ps
module test_serial_eeprom_read_ack_poll;
  localparam integer WCYC = 400;
  reg         i_clk;
  reg         i_rstn;
  reg  [2:0]  cs;
  reg  [11:0] a;
  reg  [7:0]  d0;
  reg  [7:0]  d1;
  reg  [7:0]  r;
  reg         k;
  integer     seed;
  integer     errors;
  integer     checks_done;
  integer     n;
  wire        scl;
  wire        m_low;
  wire        sda_out;
  wire        sda_oe;
  wire        busy;
  // Open-drain data line with pull-up
  wire        sda = (sda_oe ? sda_out : 1'b1) & !m_low;
  seep_top #(.WRITE_CYCLES(WCYC)) seep_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_bit_high(cs[2]), .i_chip_select_bit_mid(cs[1]),
    .i_chip_select_bit_low(cs[0]), .o_write_busy(busy));
  seep_bfm seep_bfm_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
  initial i_clk = 1'b0;
  always #25 i_clk = !i_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  function [7:0] ctl(input rw);
    ctl = {4'ha, cs, rw};
  endfunction
  task automatic st;
    seep_bfm_inst.frame(1'b0, 1'b1);
  endtask
  task automatic sp;
    seep_bfm_inst.frame(1'b1, 1'b0);
  endtask
  task automatic pk(input [7:0] b, input e);
    begin
      seep_bfm_inst.put_byte(b, k);
      chk({7'h00, k}, {7'h00, e});
    end
  endtask
  task automatic gk(input m, input [7:0] e);
    begin
      seep_bfm_inst.get_byte(m, r);
      chk(r, e);
    end
  endtask
  // Byte write, then polls: read and write tries refused while busy
  task automatic wr(input [11:0] wa, input [7:0] wd);
    begin
      st;
      pk(ctl(1'b0), 1'b1);
      pk({4'h0, wa[11:8]}, 1'b1);
      pk(wa[7:0], 1'b1);
      pk(wd, 1'b1);
      sp;
      repeat (6) @(negedge i_clk);
      chk({7'h00, busy}, 8'h01);
      st;
      pk(ctl(1'b1), 1'b0);
      st;
      pk(ctl(1'b0), 1'b0);
      k = 1'b0;
      for (n = 0; n < 20 && !k; n = n + 1) begin
        st;
        seep_bfm_inst.put_byte(ctl(1'b0), k);
      end
      chk({7'h00, k}, 8'h01);
      sp;
    end
  endtask
  // Address load by a write, then restart as read
  task automatic seta(input [11:0] sa);
    begin
      st;
      pk(ctl(1'b0), 1'b1);
      pk({4'h0, sa[11:8]}, 1'b1);
      pk(sa[7:0], 1'b1);
      st;
      pk(ctl(1'b1), 1'b1);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog: about seven times the expected run
  initial begin
    #2000000;
    errors = errors + 1;
    conclude;
  end
  initial begin
    i_rstn = 1'b0;
    seed = 75;
    errors = 0;
    checks_done = 0;
    cs = $random(seed);
    a = $random(seed);
    a[11] = 1'b0; // Keeps a+1 clear of the wrap
    d0 = $random(seed);
    d1 = $random(seed);
    repeat (4) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_clk);
    chk({6'h00, sda_oe, busy}, 8'h00);
    wr(a, d0);
    wr(a + 12'h001, d1);
    $display("test write polling done");
    seta(a);
    gk(1'b1, d0);
    gk(1'b0, d1);
    sp;
    // Restart after a data byte: nothing stored, address kept
    st;
    pk(ctl(1'b0), 1'b1);
    pk({4'h0, a[11:8]}, 1'b1);
    pk(a[7:0], 1'b1);
    pk(~d0, 1'b1);
    st;
    pk(ctl(1'b1), 1'b1);
    gk(1'b0, d0);
    sp;
    chk({7'h00, busy}, 8'h00);
    seta(a);
    gk(1'b0, d0);
    sp;
    st;
    pk(ctl(1'b1), 1'b1);
    gk(1'b0, d1);
    gk(1'b0, 8'hff);
    sp;
    $display("test reads done");
    wr(12'h000, d0);
    wr(12'hfff, d1);
    // Commit at the top wraps the counter; refused polls must not move it
    st;
    pk(ctl(1'b1), 1'b1);
    gk(1'b0, d0);
    sp;
    seta(12'hfff);
    gk(1'b1, d1);
    gk(1'b0, d0);
    sp;
    $display("test wrap done");
    for (n = 0; n < 3; n = n + 1) begin
      st;
      pk(n == 0 ? {4'hb, cs, 1'b0} : {4'ha, cs ^ (3'h1 << n), 1'b0}, 1'b0);
      sp;
    end
    $display("test select done");
    conclude;
  end
endmodule
